// [hw/acau_action_unit.sv]
// ============================================================
// ACL action and count unit for one switch port.
// Assumes the matching engine supplies the hit entry index, QoS priority,
// lookup port map and per-entry MAC and EtherType hits on the core clock.
// ============================================================
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps

module acau_action_unit
	import acau_pkg::*;
(
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	// AHB-Lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic      [31:0]             hrdata,
	// Frame action request
	input  wire logic                    act_valid,
	input  wire logic [ACAU_IDX_W-1:0]   act_index,
	input  wire logic [2:0]              qos_prio,
	input  wire logic [ACAU_PORTS-1:0]   lookup_map,
	// Frame action result
	output logic                         res_valid,
	output logic      [2:0]              res_prio,
	output logic                         res_remark,
	output logic      [2:0]              res_pcp,
	output logic      [ACAU_PORTS-1:0]   res_map,
	// Count-mode frame qualifiers
	input  wire logic                    cnt_frame_valid,
	input  wire logic [ACAU_ENTRIES-1:0] cnt_mac_hit,
	input  wire logic [ACAU_ENTRIES-1:0] cnt_type_hit,
	// Interrupt
	output logic                         port_irq
);

	// ============================================================
	// Bus address phase capture
	logic                   dp_wr_reg;
	logic                   dp_rd_reg;
	logic [7:0]             dp_addr_reg;
	logic                   ap_take;

	// Zero wait states: each transfer ends with its single data phase
	assign ap_take   = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			dp_wr_reg   <= 1'b0;
			dp_rd_reg   <= 1'b0;
			dp_addr_reg <= '0;
		end else begin
			dp_wr_reg <= ap_take && hwrite;
			dp_rd_reg <= ap_take && !hwrite;
			if (ap_take) begin
				dp_addr_reg <= haddr[7:0];
			end
		end
	end

	// ============================================================
	// Register writes
	logic [ACAU_IDX_W-1:0]   tbl_index_reg;
	logic [ACAU_ENTRIES-1:0] int_mask_reg;
	logic [ACAU_ENTRIES-1:0] int_stat_reg;
	logic [ACAU_ENTRIES-1:0] int_stat_next;
	logic [ACAU_ENTRIES-1:0] cnt_event;
	logic                    wr_index;
	logic                    wr_data;
	logic                    wr_stat;
	logic                    wr_mask;

	// Writes land at the edge that closes the data phase
	assign wr_index = dp_wr_reg && dp_addr_reg == ACAU_OFS_TBL_INDEX;
	assign wr_data  = dp_wr_reg && dp_addr_reg == ACAU_OFS_TBL_DATA;
	assign wr_stat  = dp_wr_reg && dp_addr_reg == ACAU_OFS_INT_STAT;
	assign wr_mask  = dp_wr_reg && dp_addr_reg == ACAU_OFS_INT_MASK;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tbl_index_reg <= '0;
		end else if (wr_index) begin
			tbl_index_reg <= hwdata[ACAU_IDX_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			int_mask_reg <= ACAU_RST_INT_MASK;
		end else if (wr_mask) begin
			int_mask_reg <= hwdata[ACAU_ENTRIES-1:0];
		end
	end

	// Write one to clear; a counter event in the same cycle wins
	always_comb begin
		int_stat_next = int_stat_reg;
		if (wr_stat) begin
			int_stat_next = int_stat_next & ~hwdata[ACAU_ENTRIES-1:0];
		end
		int_stat_next = int_stat_next | cnt_event;
	end

	// Level follows the status value being stored at this edge
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			int_stat_reg <= '0;
			port_irq     <= 1'b0;
		end else begin
			int_stat_reg <= int_stat_next;
			port_irq     <= |(int_stat_next & int_mask_reg);
		end
	end

	// ============================================================
	// Entry table
	logic [ACAU_WORD_W-1:0] bus_entry;
	logic [ACAU_WORD_W-1:0] act_entry;

	// Port A serves the bus, port B the frame pipeline
	acau_table_mem #(
		.WIDTH (ACAU_WORD_W),
		.DEPTH (ACAU_ENTRIES),
		.AW    (ACAU_IDX_W)
	) u_table (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.wr_en     (wr_data),
		.wr_addr   (tbl_index_reg),
		.wr_data   (hwdata),
		.rd_a_addr (tbl_index_reg),
		.rd_a_data (bus_entry),
		.rd_b_addr (act_index),
		.rd_b_data (act_entry)
	);

	// ============================================================
	// Register reads
	// Read data stay zero outside a read data phase
	always_comb begin
		hrdata = 32'h0000_0000;
		if (dp_rd_reg) begin
			case (dp_addr_reg)
				ACAU_OFS_TBL_INDEX: hrdata = {28'h000_0000, tbl_index_reg};
				ACAU_OFS_TBL_DATA:  hrdata = bus_entry;
				ACAU_OFS_INT_STAT:  hrdata = {16'h0000, int_stat_reg};
				ACAU_OFS_INT_MASK:  hrdata = {16'h0000, int_mask_reg};
				ACAU_OFS_PORT_INT:  hrdata = {31'h0000_0000, port_irq};
				default:            hrdata = 32'h0000_0000;
			endcase
		end
	end

	// ============================================================
	// Count-mode shadow of each entry, captured on table writes
	logic [ACAU_ENTRIES-1:0] cm_active_reg;
	logic [ACAU_ENTRIES-1:0] cm_algo_reg;
	logic [ACAU_ENTRIES-1:0] cm_unit_reg;
	logic [ACAU_ENTRIES-1:0] cm_reload_reg;
	logic [ACAU_COUNT_W-1:0] cm_count_reg [ACAU_ENTRIES];
	logic                    wd_count_mode;

	// Shadows let each counter run without a table read
	assign wd_count_mode = hwdata[ACAU_F_RMODE_LSB +: 2] == ACAU_RMODE_L2 &&
		hwdata[ACAU_F_CMPEN_LSB +: 2] == ACAU_CMPEN_COUNT;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cm_active_reg <= '0;
			cm_algo_reg   <= '0;
			cm_unit_reg   <= '0;
			cm_reload_reg <= '0;
			for (int i = 0; i < ACAU_ENTRIES; i++) begin
				cm_count_reg[i] <= '0;
			end
		end else begin
			cm_reload_reg <= '0;
			// A table write also restarts that entry's counter
			if (wr_data) begin
				cm_active_reg[tbl_index_reg] <= wd_count_mode;
				cm_algo_reg[tbl_index_reg]   <= hwdata[ACAU_F_CA];
				cm_unit_reg[tbl_index_reg]   <= hwdata[ACAU_F_TU];
				cm_count_reg[tbl_index_reg]  <= hwdata[ACAU_F_COUNT_LSB +: ACAU_COUNT_W];
				cm_reload_reg[tbl_index_reg] <= 1'b1;
			end
		end
	end

	// ============================================================
	// Time base ticks
	// Free-running: the first tick after a load comes early by up to one unit
	// Millisecond tick counts microsecond ticks, not core cycles
	logic [ACAU_PRE_W-1:0] us_pre_reg;
	logic [ACAU_PRE_W-1:0] ms_pre_reg;
	logic                  tick_us_reg;
	logic                  tick_ms_reg;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			us_pre_reg  <= '0;
			ms_pre_reg  <= '0;
			tick_us_reg <= 1'b0;
			tick_ms_reg <= 1'b0;
		end else begin
			tick_us_reg <= 1'b0;
			tick_ms_reg <= 1'b0;
			if (us_pre_reg == ACAU_PRE_W'(ACAU_US_CYCLES - 1)) begin
				us_pre_reg  <= '0;
				tick_us_reg <= 1'b1;
				if (ms_pre_reg == ACAU_PRE_W'(ACAU_US_PER_MS - 1)) begin
					ms_pre_reg  <= '0;
					tick_ms_reg <= 1'b1;
				end else begin
					ms_pre_reg <= ms_pre_reg + 10'h001;
				end
			end else begin
				us_pre_reg <= us_pre_reg + 10'h001;
			end
		end
	end

	// ============================================================
	// Per-entry counters
	logic [ACAU_ENTRIES-1:0] cnt_qualify;

	// Only a frame with both hits counts or restarts a timer
	assign cnt_qualify = {ACAU_ENTRIES{cnt_frame_valid}} & cnt_mac_hit & cnt_type_hit;

	// One counter per entry; inactive entries stay loaded and idle
	for (genvar g = 0; g < ACAU_ENTRIES; g++) begin : g_cnt
		acau_counter u_cnt (
			.ref_clk   (ref_clk),
			.reset_n   (reset_n),
			.active    (cm_active_reg[g]),
			.algo_up   (cm_algo_reg[g]),
			.unit_ms   (cm_unit_reg[g]),
			.count_val (cm_count_reg[g]),
			.reload    (cm_reload_reg[g]),
			.qualify   (cnt_qualify[g] && cm_active_reg[g]),
			.tick_us   (tick_us_reg),
			.tick_ms   (tick_ms_reg),
			.expire    (cnt_event[g])
		);
	end

	// ============================================================
	// Action pipeline: stage one waits for the table read
	// Request fields wait one cycle for the registered table read
	logic                  s1_valid_reg;
	logic [2:0]            s1_qos_reg;
	logic [ACAU_PORTS-1:0] s1_map_reg;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s1_valid_reg <= 1'b0;
			s1_qos_reg   <= '0;
			s1_map_reg   <= '0;
		end else begin
			s1_valid_reg <= act_valid;
			s1_qos_reg   <= qos_prio;
			s1_map_reg   <= lookup_map;
		end
	end

	// ============================================================
	// Action decode
	acau_pmode_type        pmode;
	acau_mmode_type        mmode;
	logic [2:0]            a_prio;
	logic [ACAU_PORTS-1:0] a_map;
	logic                  a_count_mode;
	logic [2:0]            prio_next;
	logic [ACAU_PORTS-1:0] map_next;
	logic                  remark_next;

	// Count-mode entries hold the count in the action bits,
	// so they pass priority and map through and never remark
	assign pmode        = acau_pmode_type'(act_entry[ACAU_F_PMODE_LSB +: 2]);
	assign mmode        = acau_mmode_type'(act_entry[ACAU_F_MMODE_LSB +: 2]);
	assign a_prio       = act_entry[ACAU_F_PRIO_LSB +: 3];
	assign a_map        = act_entry[ACAU_F_MAP_LSB +: ACAU_PORTS];
	assign a_count_mode = act_entry[ACAU_F_RMODE_LSB +: 2] == ACAU_RMODE_L2 &&
		act_entry[ACAU_F_CMPEN_LSB +: 2] == ACAU_CMPEN_COUNT;

	always_comb begin
		prio_next = s1_qos_reg;
		case (pmode)
			ACAU_PM_QOS:   prio_next = s1_qos_reg;
			ACAU_PM_RAISE: prio_next = (a_prio > s1_qos_reg) ? a_prio : s1_qos_reg;
			ACAU_PM_LOWER: prio_next = (a_prio < s1_qos_reg) ? a_prio : s1_qos_reg;
			ACAU_PM_FORCE: prio_next = a_prio;
			default:       prio_next = s1_qos_reg;
		endcase
		if (a_count_mode) begin
			prio_next = s1_qos_reg;
		end
	end

	always_comb begin
		map_next = s1_map_reg;
		case (mmode)
			ACAU_MM_KEEP: map_next = s1_map_reg;
			ACAU_MM_OR:   map_next = s1_map_reg | a_map;
			ACAU_MM_AND:  map_next = s1_map_reg & a_map;
			ACAU_MM_REPL: map_next = a_map;
			default:      map_next = s1_map_reg;
		endcase
		if (a_count_mode) begin
			map_next = s1_map_reg;
		end
	end

	assign remark_next = act_entry[ACAU_F_RMK_EN] && !a_count_mode;

	// ============================================================
	// Result registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			res_valid  <= 1'b0;
			res_prio   <= '0;
			res_remark <= 1'b0;
			res_pcp    <= '0;
			res_map    <= '0;
		end else begin
			res_valid  <= s1_valid_reg;
			// Result fields hold until the next request
			if (s1_valid_reg) begin
				res_prio   <= prio_next;
				res_remark <= remark_next;
				res_pcp    <= remark_next ? act_entry[ACAU_F_RMK_LSB +: 3] : 3'h0;
				res_map    <= map_next;
			end
		end
	end

endmodule // acau_action_unit

// [hw/acau_pkg.sv]
// ============================================================
// Package for the ACL action and count unit
// Holds register offsets, entry field layout, timing counts and codes.
// Assumes a single 125 MHz core clock and an AHB-Lite register bus.
// ============================================================
// Overview of operation
// - Priority mode picks keep, raise, lower, force.
// - Remark enable replaces VLAN PCP with value.
// - Map mode keeps, ORs, ANDs or replaces map.
// - Port map bit n forwards to port n+1.
// - Count mode alone couples matching and action.
// - Table holds sixteen entries, three fields each.
// - Time unit: zero microsecond, one millisecond.
// - Timeout: down-counter expiry raises interrupt.
// - Packet count: terminal count interrupts, then clears.
// - Only count-mode entries may raise interrupts.
// - Per-port status and mask feed top level.
// - Count value overlays priority, remark, map-mode fields.
// - Count needs both MAC and EtherType match.
package acau_pkg;

	// ============================================================
	// Table geometry
	localparam int ACAU_ENTRIES     = 16;
	localparam int ACAU_IDX_W       = 4;
	localparam int ACAU_WORD_W      = 32;
	localparam int ACAU_PORTS       = 3;
	localparam int ACAU_COUNT_W     = 11;

	// ============================================================
	// Entry word layout (action, matching mode and process fields)
	localparam int ACAU_F_PMODE_LSB = 0;
	localparam int ACAU_F_PRIO_LSB  = 2;
	localparam int ACAU_F_RMK_EN    = 5;
	localparam int ACAU_F_RMK_LSB   = 6;
	localparam int ACAU_F_MMODE_LSB = 9;
	localparam int ACAU_F_COUNT_LSB = 0;
	localparam int ACAU_F_TU        = 11;
	localparam int ACAU_F_CA        = 12;
	localparam int ACAU_F_MAP_LSB   = 13;
	localparam int ACAU_F_RMODE_LSB = 16;
	localparam int ACAU_F_CMPEN_LSB = 18;
	localparam int ACAU_F_PROC_LSB  = 20;

	localparam logic [1:0] ACAU_RMODE_L2    = 2'h1;
	localparam logic [1:0] ACAU_CMPEN_COUNT = 2'h0;

	// ============================================================
	// Mode codes
	typedef enum logic [1:0] {
		ACAU_PM_QOS    = 2'h0,
		ACAU_PM_RAISE  = 2'h1,
		ACAU_PM_LOWER  = 2'h2,
		ACAU_PM_FORCE  = 2'h3
	} acau_pmode_type;

	typedef enum logic [1:0] {
		ACAU_MM_KEEP   = 2'h0,
		ACAU_MM_OR     = 2'h1,
		ACAU_MM_AND    = 2'h2,
		ACAU_MM_REPL   = 2'h3
	} acau_mmode_type;

	// ============================================================
	// Register byte offsets
	localparam logic [7:0] ACAU_OFS_TBL_INDEX = 8'h00;
	localparam logic [7:0] ACAU_OFS_TBL_DATA  = 8'h04;
	localparam logic [7:0] ACAU_OFS_INT_STAT  = 8'h08;
	localparam logic [7:0] ACAU_OFS_INT_MASK  = 8'h0C;
	localparam logic [7:0] ACAU_OFS_PORT_INT  = 8'h10;

	localparam logic [15:0] ACAU_RST_INT_MASK = 16'h0000;

	// ============================================================
	// Timing
	localparam int ACAU_CLK_PERIOD_PS = 8000;
	localparam int ACAU_TICK_US_PS    = 1000000;
	localparam int ACAU_US_CYCLES     = ACAU_TICK_US_PS / ACAU_CLK_PERIOD_PS;
	localparam int ACAU_US_PER_MS     = 1000;
	localparam int ACAU_PRE_W         = 10;

endpackage : acau_pkg

// [hw/acau_table_mem.sv]
// ============================================================
// Entry table memory: one write port, two registered read ports.
// Assumes callers present stable addresses; read data lag one cycle.
// ============================================================
`timescale 1ns/1ps

module acau_table_mem
	import acau_pkg::*;
#(
	parameter int WIDTH = ACAU_WORD_W,
	parameter int DEPTH = ACAU_ENTRIES,
	parameter int AW    = ACAU_IDX_W
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// Write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read ports
	input  wire logic [AW-1:0]    rd_a_addr,
	output logic      [WIDTH-1:0] rd_a_data,
	input  wire logic [AW-1:0]    rd_b_addr,
	output logic      [WIDTH-1:0] rd_b_data
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rd_a_data <= '0;
			rd_b_data <= '0;
		end else begin
			rd_a_data <= mem_reg[rd_a_addr];
			rd_b_data <= mem_reg[rd_b_addr];
		end
	end

endmodule // acau_table_mem

// [hw/acau_counter.sv]
// ============================================================
// One count-mode counter: timeout down-count or packet up-count.
// Assumes tick pulses and qualify pulses are one cycle wide.
// ============================================================
`timescale 1ns/1ps

module acau_counter
	import acau_pkg::*;
(
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	// Configuration
	input  wire logic                    active,
	input  wire logic                    algo_up,
	input  wire logic                    unit_ms,
	input  wire logic [ACAU_COUNT_W-1:0] count_val,
	input  wire logic                    reload,
	// Events
	input  wire logic                    qualify,
	input  wire logic                    tick_us,
	input  wire logic                    tick_ms,
	output logic                         expire
);

	logic [ACAU_COUNT_W-1:0] cnt_reg;
	logic                    armed_reg;
	logic                    tick;

	assign tick = unit_ms ? tick_ms : tick_us;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_reg   <= '0;
			armed_reg <= 1'b0;
			expire    <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (!active || reload) begin
				cnt_reg   <= algo_up ? '0 : count_val;
				armed_reg <= active && !algo_up;
			end else if (algo_up) begin
				if (qualify) begin
					if (cnt_reg + 11'h001 == count_val) begin
						cnt_reg <= '0;
						expire  <= 1'b1;
					end else begin
						cnt_reg <= cnt_reg + 11'h001;
					end
				end
			end else if (qualify) begin
				cnt_reg   <= count_val;
				armed_reg <= 1'b1;
			end else if (armed_reg && tick) begin
				if (cnt_reg <= 11'h001) begin
					cnt_reg   <= '0;
					armed_reg <= 1'b0;
					expire    <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - 11'h001;
				end
			end
		end
	end

endmodule // acau_counter

// [testbench/acau_chk.sv]
// Port checker for the ACL action and count unit.
// Bound into acau_action_unit; sees its ports only.
`timescale 1ns/1ps

module acau_chk
	import acau_pkg::*;
(
	// Clock and reset
	input wire logic                  ref_clk,
	input wire logic                  reset_n,
	// Register bus
	input wire logic                  hsel,
	input wire logic [31:0]           haddr,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic                  hready,
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	input wire logic [31:0]           hrdata,
	// Frame path and interrupt
	input wire logic                  act_valid,
	input wire logic                  res_valid,
	input wire logic [2:0]            res_prio,
	input wire logic                  res_remark,
	input wire logic [2:0]            res_pcp,
	input wire logic [ACAU_PORTS-1:0] res_map,
	input wire logic                  port_irq
);
	// ============================================================
	// Data phase tracking
	logic       wr_ph_reg;
	logic       rd_ph_reg;
	logic [7:0] ph_addr_reg;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wr_ph_reg   <= 1'b0;
			rd_ph_reg   <= 1'b0;
			ph_addr_reg <= 8'h00;
		end else if (hready) begin
			wr_ph_reg   <= hsel && htrans[1] && hwrite;
			rd_ph_reg   <= hsel && htrans[1] && !hwrite;
			ph_addr_reg <= haddr[7:0];
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// ============================================================
	// Properties
	chk_res_latency: assert property (act_valid |-> ##2 res_valid)
		else $error("no result two cycles after request");
	chk_res_cause: assert property (res_valid |-> $past(act_valid, 2))
		else $error("result without request");
	chk_res_hold: assert property (!res_valid |-> $stable({res_prio, res_remark, res_pcp, res_map}))
		else $error("result changed without result pulse");
	chk_pcp_quiet: assert property (!res_remark |-> res_pcp == 3'h0)
		else $error("pcp driven while remark off");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus wait or error response");
	chk_rdata_idle: assert property (!rd_ph_reg |-> hrdata == 32'h0)
		else $error("read data outside read data phase");
	chk_irq_read: assert property (rd_ph_reg && ph_addr_reg == ACAU_OFS_PORT_INT |-> hrdata == {31'h0, port_irq})
		else $error("port interrupt register differs from output");
	chk_irq_clear: assert property ($fell(port_irq) |-> $past(wr_ph_reg) || $past(wr_ph_reg, 2))
		else $error("interrupt dropped without register write");
endmodule // acau_chk

bind acau_action_unit acau_chk u_chk (
	.ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
	.act_valid, .res_valid, .res_prio, .res_remark, .res_pcp, .res_map, .port_irq
);

// [testbench/acau_pipe_model.sv]
// Model of the lookup, QoS and matching pipeline feeding the unit.
// Driven by bench task calls made just after a rising edge.
`timescale 1ns/1ps

module acau_pipe_model
	import acau_pkg::*;
(
	// Clock
	input  wire logic                    ref_clk,
	// Frame action request
	output logic                         act_valid,
	output logic      [ACAU_IDX_W-1:0]   act_index,
	output logic      [2:0]              qos_prio,
	output logic      [ACAU_PORTS-1:0]   lookup_map,
	// Count qualifiers
	output logic                         cnt_frame_valid,
	output logic      [ACAU_ENTRIES-1:0] cnt_mac_hit,
	output logic      [ACAU_ENTRIES-1:0] cnt_type_hit
);
	initial begin
		act_valid       = 1'b0;
		act_index       = '0;
		qos_prio        = 3'h0;
		lookup_map      = '0;
		cnt_frame_valid = 1'b0;
		cnt_mac_hit     = '0;
		cnt_type_hit    = '0;
	end

	// Idle qualifiers show inverted garbage, never the last value
	task automatic send_act(input logic [ACAU_IDX_W-1:0] i, input logic [2:0] q, input logic [ACAU_PORTS-1:0] m);
		act_valid  <= 1'b1;
		act_index  <= i;
		qos_prio   <= q;
		lookup_map <= m;
		@(posedge ref_clk);
		act_valid  <= 1'b0;
		act_index  <= ~i;
		qos_prio   <= ~q;
		lookup_map <= ~m;
	endtask

	task automatic send_frame(input logic [ACAU_ENTRIES-1:0] mh, input logic [ACAU_ENTRIES-1:0] th);
		cnt_frame_valid <= 1'b1;
		cnt_mac_hit     <= mh;
		cnt_type_hit    <= th;
		@(posedge ref_clk);
		cnt_frame_valid <= 1'b0;
		cnt_mac_hit     <= ~mh;
		cnt_type_hit    <= ~th;
		@(posedge ref_clk);
	endtask
endmodule // acau_pipe_model

// [testbench/acau_action_unit_test.sv]
// Self-checking bench for the ACL action and count unit.
// Bench is the bus master; acau_pipe_model supplies frames.
`timescale 1ns/1ps

module acau_action_unit_test
	import acau_pkg::*;
;
	logic                    ref_clk = 1'b0;
	logic                    reset_n = 1'b0;
	logic                    hsel    = 1'b0;
	logic [31:0]             haddr   = 32'h0;
	logic [1:0]              htrans  = 2'h0;
	logic                    hwrite  = 1'b0;
	logic [2:0]              hsize   = 3'h2;
	logic [31:0]             hwdata  = 32'h0;
	wire logic               hready;
	logic                    hreadyout, hresp, port_irq;
	logic [31:0]             hrdata;
	logic                    act_valid, res_valid, res_remark, cnt_frame_valid;
	logic [ACAU_IDX_W-1:0]   act_index;
	logic [2:0]              qos_prio, res_prio, res_pcp;
	logic [ACAU_PORTS-1:0]   lookup_map, res_map;
	logic [ACAU_ENTRIES-1:0] cnt_mac_hit, cnt_type_hit;
	int                      fail_count = 0;
	int                      tests_run  = 0;

	assign hready = hreadyout;

	acau_action_unit dut (.*);
	acau_pipe_model pipe (.ref_clk, .act_valid, .act_index, .qos_prio, .lookup_map,
		.cnt_frame_valid, .cnt_mac_hit, .cnt_type_hit);

	initial forever #4 ref_clk = ~ref_clk;

	// ============================================================
	// Helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic wait_rdy();
		@(posedge ref_clk);
		for (int n = 0; n < 100 && hready !== 1'b1; n++) @(posedge ref_clk);
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0, x);
		check(x, e);
	endtask

	task automatic wr_ent(input logic [3:0] i, input logic [31:0] d);
		wr(ACAU_OFS_TBL_INDEX, {28'h0, i});
		wr(ACAU_OFS_TBL_DATA, d);
	endtask

	// Entry word: process field, enables, rule mode, map, algorithm, unit, low field
	function automatic logic [31:0] ent(input logic [10:0] lo, input logic tu, input logic ca,
		input logic [2:0] fwd, input logic cnt);
		ent = {12'hA5C, cnt ? 2'h0 : 2'h3, 2'h1, fwd, ca, tu, lo};
	endfunction

	task automatic act_chk(input logic [3:0] i, input logic [2:0] q, input logic [2:0] m, input logic [9:0] e);
		pipe.send_act(i, q, m);
		repeat (2) @(posedge ref_clk);
		check({21'h0, res_valid, res_prio, res_remark, res_pcp, res_map}, {22'h1, e});
	endtask

	// ============================================================
	// Scenarios
	task automatic test_regs();
		rd_chk(ACAU_OFS_TBL_INDEX, 32'h0);
		rd_chk(ACAU_OFS_INT_MASK, 32'h0);
		rd_chk(ACAU_OFS_INT_STAT, 32'h0);
		wr(8'h14, 32'hFFFFFFFF);
		rd_chk(8'h14, 32'h0);
	endtask

	task automatic test_prio();
		logic [2:0] e;
		for (int pm = 0; pm < 4; pm++) begin
			wr_ent(4'(pm * 5), ent({2'h0, 3'h0, 1'b0, 3'h4, 2'(pm)}, 1'b0, 1'b0, 3'h0, 1'b0));
			for (int q = 2; q < 8; q += 4) begin
				case (pm)
					0: e = 3'(q);
					1: e = (q < 4) ? 3'h4 : 3'(q);
					2: e = (q > 4) ? 3'h4 : 3'(q);
					default: e = 3'h4;
				endcase
				act_chk(4'(pm * 5), 3'(q), 3'h6, {e, 1'b0, 3'h0, 3'h6});
			end
		end
	endtask

	task automatic test_map();
		logic [2:0] e;
		for (int mm = 0; mm < 4; mm++) begin
			wr_ent(4'h1, ent({2'(mm), 3'h6, 1'(mm % 2), 3'h0, 2'h0}, 1'b0, 1'b0, 3'h5, 1'b0));
			case (mm)
				0: e = 3'h3;
				1: e = 3'h7;
				2: e = 3'h1;
				default: e = 3'h5;
			endcase
			act_chk(4'h1, 3'h2, 3'h3, {3'h2, 1'(mm % 2), (mm % 2) ? 3'h6 : 3'h0, e});
		end
		rd_chk(ACAU_OFS_INT_STAT, 32'h0);
	endtask

	task automatic test_pass();
		wr_ent(4'h2, ent(11'h7FF, 1'b0, 1'b1, 3'h4, 1'b1));
		rd_chk(ACAU_OFS_TBL_DATA, ent(11'h7FF, 1'b0, 1'b1, 3'h4, 1'b1));
		act_chk(4'h2, 3'h1, 3'h2, {3'h1, 1'b0, 3'h0, 3'h2});
	endtask

	task automatic test_up();
		wr(ACAU_OFS_INT_MASK, 32'h8);
		wr_ent(4'h3, ent(11'h3, 1'b1, 1'b1, 3'h0, 1'b1));
		pipe.send_frame(16'h8, 16'h0);
		repeat (2) pipe.send_frame(16'h8, 16'h8);
		repeat (4) @(posedge ref_clk);
		check(32'(port_irq), 32'h0);
		pipe.send_frame(16'h8, 16'h8);
		repeat (4) @(posedge ref_clk);
		check(32'(port_irq), 32'h1);
		rd_chk(ACAU_OFS_INT_STAT, 32'h8);
		rd_chk(ACAU_OFS_PORT_INT, 32'h1);
		wr(ACAU_OFS_INT_STAT, 32'h8);
		rd_chk(ACAU_OFS_PORT_INT, 32'h0);
		wr(ACAU_OFS_INT_MASK, 32'h0);
		repeat (3) pipe.send_frame(16'h8, 16'h8);
		repeat (4) @(posedge ref_clk);
		rd_chk(ACAU_OFS_INT_STAT, 32'h8);
		check(32'(port_irq), 32'h0);
		wr(ACAU_OFS_INT_STAT, 32'h8);
	endtask

	task automatic test_timeout();
		int n;
		wr(ACAU_OFS_INT_MASK, 32'h20);
		wr_ent(4'h6, ent(11'h4, 1'b1, 1'b0, 3'h0, 1'b1));
		wr_ent(4'h5, ent(11'h4, 1'b0, 1'b0, 3'h0, 1'b1));
		repeat (5) begin
			repeat (200) @(posedge ref_clk);
			pipe.send_frame(16'h20, 16'h20);
		end
		check(32'(port_irq), 32'h0);
		n = 0;
		while (port_irq !== 1'b1 && n < 800) begin
			@(posedge ref_clk);
			n++;
		end
		check(32'(n >= 360 && n <= 660), 32'h1);
		rd_chk(ACAU_OFS_INT_STAT, 32'h20);
	endtask

	task automatic end_of_test();
		$display("Checks %0d, errors %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ============================================================
	// Main sequence and watchdog
	initial begin
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		test_regs();
		test_prio();
		test_map();
		test_pass();
		test_up();
		test_timeout();
		end_of_test();
	end

	initial begin
		repeat (30000) @(posedge ref_clk);
		fail_count++;
		$display("ERROR %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule // acau_action_unit_test
